// *** hw/ctc_core_timer_control.sv ***
// core 16-bit timer with control register and apb slave
// Function
// - reset clears the control register and the count register to zero.
// - the input parameter field means prescale in timer/gated modes, edge choice otherwise.
// - the mode field picks timer, counter, gated low/high or incremental; 100/101 reserved.
// - the run bit lets the timer advance when one and holds it when zero.
// - outside the incremental modes, with external direction off, the direction bit counts up at zero, down at one.
// - outside the incremental modes, the external direction enable takes the direction from the external line.
// - the toggle latch inverts on each over/underflow and software may write it.
// - the block prescaler divides the clock by 8, 4, 32 or 16 for codes 00..11.
// - in timer and gated modes each parameter step doubles the divider, 4 to 4096.
// - edge and direction-change flags are set by hardware and cleared by software.
`timescale 1ns/10ps
module ctc_core_timer_control (
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    resetn_i,
  // apb slave
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [ctc_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // external lines
  input  wire logic                    count_input_line_i,
  input  wire logic                    ext_dir_line_i,
  // outputs
  output logic                         toggle_output_pin_o,
  output logic      [15:0]             count_o
);
  import ctc_pkg::*;

  logic [1:0]          rst_sync_r;
  logic                rst_n;
  ctc_ctrl_type        ctrl_r;
  ctc_ctrl_type        ctrl_nxt;
  logic [15:0]         count_r;
  logic [15:0]         count_nxt;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic                pin_r;
  wire  [1:0]          pin_in = {ext_dir_line_i, count_input_line_i};
  logic [1:0]          lvl_r;
  logic [1:0]          lvl_nxt;
  logic [1:0]          chg;

  // release reset through two flops
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // pin synchronisers: a change counts once stages two and three agree
  // each line keeps its flops local so no variable has two writing processes
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [SYNC_STAGES-1:0] stg_r;
    logic                   hold_r;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        stg_r  <= '0;
        hold_r <= 1'b0;
      end else begin
        stg_r  <= {stg_r[SYNC_STAGES-2:0], pin_in[g]};
        hold_r <= lvl_nxt[g];
      end
    end
    assign lvl_r[g]   = hold_r;
    assign lvl_nxt[g] = (stg_r[1] == stg_r[2]) ? stg_r[2] : hold_r;
    assign chg[g]     = lvl_nxt[g] != hold_r;
  end

  // apb decode: one wait state, data and pready both from flops
  wire access    = psel_i && penable_i;
  wire hit_ctrl  = (paddr_i == CTRL_OFS);
  wire hit_count = (paddr_i == COUNT_OFS);
  wire hit_any   = hit_ctrl || hit_count;
  wire done      = access && pready_r;
  wire wr_ctrl   = done && pwrite_i && hit_ctrl;
  wire wr_count  = done && pwrite_i && hit_count;
  wire [31:0] rd_val = hit_ctrl  ? {16'h0000, ctrl_r} :
                       hit_count ? {16'h0000, count_r} : 32'h0000_0000;

  // mode decoding
  wire [2:0] mode      = ctrl_r.timer_mode_sel;
  wire [2:0] param     = ctrl_r.input_param_sel;
  wire is_timer        = (mode == MODE_TIMER);
  wire is_gate_lo      = (mode == MODE_GATE_LO);
  wire is_gate_hi      = (mode == MODE_GATE_HI);
  wire is_counter      = (mode == MODE_COUNTER);
  wire is_incr         = (mode == MODE_INC_ROT) || (mode == MODE_INC_EDGE);
  wire prescaled       = is_timer || is_gate_lo || is_gate_hi;
  wire run             = ctrl_r.timer_run_bit;
  wire presc_tick;

  ctc_prescaler u_presc (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .enable_i  (prescaled && run),
    .bps_i     (ctrl_r.block_prescaler_sel),
    .param_i   (param),
    .tick_o    (presc_tick)
  );

  // counter mode edges on the count input
  wire in_rise  = chg[0] && lvl_nxt[0];
  wire in_fall  = chg[0] && !lvl_nxt[0];
  wire cnt_edge = (param == EDGE_RISE && in_rise) || (param == EDGE_FALL && in_fall) ||
                  (param == EDGE_ANY && chg[0]);
  // incremental mode: any edge on either line per parameter code
  wire inc_edge = (param == EDGE_RISE && chg[0]) || (param == EDGE_FALL && chg[1]) ||
                  (param == EDGE_ANY && (chg[0] || chg[1]));
  wire gate_ok  = is_timer || (is_gate_lo && !lvl_r[0]) || (is_gate_hi && lvl_r[0]);
  wire edge_ok  = (is_counter && cnt_edge) || (is_incr && inc_edge);
  // reserved modes never advance
  wire tick     = run && ((prescaled && presc_tick && gate_ok) || edge_ok);

  // quadrature direction: down when lines differ after an edge on the count input
  wire quad_down = chg[0] ? (lvl_nxt[0] ^ lvl_nxt[1]) : !(lvl_nxt[0] ^ lvl_nxt[1]);
  wire dir_down  = (is_incr && inc_edge) ? quad_down :
                   is_incr ? ctrl_r.rotation_dir_status :
                   ctrl_r.ext_dir_enable ? lvl_r[1] : ctrl_r.count_dir_bit;
  wire wrap      = tick && (dir_down ? (count_r == 16'h0000) : (count_r == 16'hffff));
  wire [15:0] count_step = dir_down ? count_r - 16'h0001 : count_r + 16'h0001;
  wire dir_chg   = dir_down != ctrl_r.rotation_dir_status;

  // control word next value: hardware set wins over a software clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = ctc_ctrl_type'(pwdata_i[15:0]);
      ctrl_nxt.rotation_dir_status = ctrl_r.rotation_dir_status;
    end
    ctrl_nxt.output_toggle_latch = ctrl_nxt.output_toggle_latch ^ wrap;
    if (edge_ok && run) begin
      ctrl_nxt.edge_seen_flag = 1'b1;
    end
    if (dir_chg) begin
      ctrl_nxt.dir_change_flag = 1'b1;
    end
    ctrl_nxt.rotation_dir_status = dir_down;
  end

  // a software write to the count wins over a tick in the same cycle
  assign count_nxt = wr_count ? pwdata_i[15:0] : tick ? count_step : count_r;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= CTRL_RESET;
      count_r <= COUNT_RESET;
      pin_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      count_r <= count_nxt;
      pin_r   <= ctrl_nxt.toggle_output_enable && ctrl_nxt.output_toggle_latch;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= access && !pready_r;
      pslverr_r <= access && !pready_r && !hit_any;
      prdata_r  <= (access && !pready_r && !pwrite_i) ? rd_val : 32'h0000_0000;
    end
  end

  assign prdata_o            = prdata_r;
  assign pready_o            = pready_r;
  assign pslverr_o           = pslverr_r;
  assign toggle_output_pin_o = pin_r;
  assign count_o             = count_r;

  // checks
  sequence seq_release;
    !rst_n ##1 rst_n;
  endsequence
  sequence seq_up_tick;
    tick && !dir_down && !wr_count;
  endsequence

  AST_RESET_CLEAR: assert property (@(posedge clk_sys_i)
    seq_release |-> (ctrl_r == CTRL_RESET) && (count_r == COUNT_RESET))
    else $error("registers not cleared by reset");
  AST_MODE_COUNTER: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (tick && is_counter) |-> cnt_edge)
    else $error("counter mode advanced without a selected edge");
  AST_PARAM_RISE: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (tick && is_counter && param == EDGE_RISE) |-> in_rise)
    else $error("rising edge choice ignored");
  AST_RUN_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (!run && !wr_count) |=> count_r == $past(count_r))
    else $error("stopped timer moved");
  AST_COUNT_UP: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    seq_up_tick |=> count_r == $past(count_r) + 16'h0001)
    else $error("up count wrong");
  AST_EXT_DIR: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (ctrl_r.ext_dir_enable && !is_incr) |-> dir_down == lvl_r[1])
    else $error("external direction not followed");
  AST_TOGGLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (wrap && !wr_ctrl) |=> ctrl_r.output_toggle_latch != $past(ctrl_r.output_toggle_latch))
    else $error("toggle latch missed a wrap");
  AST_EDGE_FLAG: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (run && edge_ok) |=> ctrl_r.edge_seen_flag ##1 (ctrl_r.edge_seen_flag || $past(wr_ctrl)))
    else $error("edge flag not set or lost");
  AST_CHDIR_FLAG: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    dir_chg |=> ctrl_r.dir_change_flag)
    else $error("direction change flag not set");
  AST_RESERVED: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (mode == 3'h4 || mode == 3'h5) |-> !tick)
    else $error("reserved mode advanced");

endmodule // ctc_core_timer_control

// *** hw/ctc_pkg.sv ***
// package: constants and types of the core timer control block
package ctc_pkg;

  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned APB_AW        = 12;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] COUNT_OFS     = 12'h004;

  // values after reset
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;

  // field positions inside the control word
  localparam int unsigned PARAM_POS     = 0;
  localparam int unsigned MODE_POS      = 3;
  localparam int unsigned RUN_POS       = 6;
  localparam int unsigned DIR_POS       = 7;
  localparam int unsigned EXTDIR_POS    = 8;
  localparam int unsigned OE_POS        = 9;
  localparam int unsigned OTL_POS       = 10;
  localparam int unsigned BPS_POS       = 11;
  localparam int unsigned EDGE_POS      = 13;
  localparam int unsigned CHDIR_POS     = 14;
  localparam int unsigned RDIR_POS      = 15;

  // mode field codes
  localparam logic [2:0] MODE_TIMER     = 3'h0;
  localparam logic [2:0] MODE_COUNTER   = 3'h1;
  localparam logic [2:0] MODE_GATE_LO   = 3'h2;
  localparam logic [2:0] MODE_GATE_HI   = 3'h3;
  localparam logic [2:0] MODE_INC_ROT   = 3'h6;
  localparam logic [2:0] MODE_INC_EDGE  = 3'h7;

  // input parameter codes for counter and incremental modes
  localparam logic [2:0] EDGE_RISE      = 3'h1;
  localparam logic [2:0] EDGE_FALL      = 3'h2;
  localparam logic [2:0] EDGE_ANY       = 3'h3;

  // log2 of the base divider per block prescaler code: 8, 4, 32, 16
  localparam logic [3:0] BPS_SHIFT_00   = 4'h3;
  localparam logic [3:0] BPS_SHIFT_01   = 4'h2;
  localparam logic [3:0] BPS_SHIFT_10   = 4'h5;
  localparam logic [3:0] BPS_SHIFT_11   = 4'h4;
  localparam int unsigned PRESC_W       = 12;

  localparam int unsigned SYNC_STAGES   = 3;

  typedef struct packed {
    logic       rotation_dir_status;
    logic       dir_change_flag;
    logic       edge_seen_flag;
    logic [1:0] block_prescaler_sel;
    logic       output_toggle_latch;
    logic       toggle_output_enable;
    logic       ext_dir_enable;
    logic       count_dir_bit;
    logic       timer_run_bit;
    logic [2:0] timer_mode_sel;
    logic [2:0] input_param_sel;
  } ctc_ctrl_type;

endpackage

// *** hw/ctc_prescaler.sv ***
// prescaler: divided count tick for timer and gated modes
`timescale 1ns/10ps
module ctc_prescaler (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        enable_i,
  input  wire logic [1:0]  bps_i,
  input  wire logic [2:0]  param_i,
  // tick out
  output logic             tick_o
);
  import ctc_pkg::*;

  logic [PRESC_W-1:0] cnt_r;
  logic [PRESC_W-1:0] cnt_nxt;
  logic [3:0]         base_shift;
  logic [3:0]         shift;
  logic [PRESC_W:0]   div_full;
  logic [PRESC_W-1:0] div_m1;
  logic               wrap;

  // each step of the parameter code doubles the divider
  assign base_shift = (bps_i == 2'h0) ? BPS_SHIFT_00 :
                      (bps_i == 2'h1) ? BPS_SHIFT_01 :
                      (bps_i == 2'h2) ? BPS_SHIFT_10 : BPS_SHIFT_11;
  assign shift    = base_shift + {1'b0, param_i};
  assign div_full = ({{PRESC_W{1'b0}}, 1'b1} << shift) - {{PRESC_W{1'b0}}, 1'b1};
  assign div_m1   = div_full[PRESC_W-1:0];
  assign wrap     = (cnt_r == div_m1);
  assign cnt_nxt  = (!enable_i || wrap) ? '0 : cnt_r + {{(PRESC_W-1){1'b0}}, 1'b1};
  // tick is only asserted while enabled, so a stopped timer restarts a full period
  assign tick_o   = enable_i && wrap;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  AST_TICK_PERIOD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tick_o |=> (cnt_r == '0) && !tick_o || (div_m1 == '0))
    else $error("prescaler tick not followed by restart");
  AST_TICK_SPACING: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tick_o |-> cnt_r == div_m1)
    else $error("prescaler tick at wrong count");

endmodule // ctc_prescaler

// *** verif/ctc_line_model.sv ***
// external count and direction lines driven by a simple line model
`timescale 1ns/10ps
module ctc_line_model (
  // clock
  input  wire logic clk_sys_i,
  // lines towards the timer
  output logic      count_line_o,
  output logic      dir_line_o
);
  initial begin
    count_line_o = 1'b0;
    dir_line_o   = 1'b0;
  end

  // levels are held 8 clocks, well past the 3-flop input filter
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      count_line_o <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      count_line_o <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
    end
  endtask

  task automatic set_dir(input logic v);
    @(posedge clk_sys_i);
    dir_line_o <= v;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule // ctc_line_model

// *** verif/testbench.sv ***
// self-checking bench for the core timer control block
`timescale 1ns/10ps
module testbench;
  import ctc_pkg::*;
  logic        clk_sys_i;
  logic        resetn_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] cst;
  logic [15:0] count;
  wire         cl;
  wire         dl;
  int          num_errors = 0;
  int          checks = 0;
  int          bt[6] = '{0, 1, 2, 3, 0, 1};
  int          pt[6] = '{0, 0, 0, 0, 1, 7};
  int          dv[6] = '{8, 4, 32, 16, 16, 512};
  int          per[4] = '{0, 1, 1, 2};

  ctc_core_timer_control dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .count_input_line_i(cl),
    .ext_dir_line_i(dl), .toggle_output_pin_o(pin), .count_o(count));
  ctc_line_model line (.clk_sys_i(clk_sys_i), .count_line_o(cl), .dir_line_o(dl));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // caller stands just after a rising edge; request held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r & m, exp);
  endtask

  function automatic logic [31:0] cw(input logic [2:0] m, input logic [2:0] p,
                                     input logic r, input logic [1:0] b);
    return 32'({b, 4'h0, r, m, p});
  endfunction

  // run from a start count, snapshot control while running, then stop
  task automatic run_for(input logic [15:0] s, input logic [31:0] c, input int cyc,
                         input int np);
    logic e;
    wr(COUNT_OFS, 32'(s));
    wr(CTRL_OFS, c);
    line.pulse(np);
    repeat (cyc) @(posedge clk_sys_i);
    apb(1'b0, CTRL_OFS, 32'h0, cst, e);
    wr(CTRL_OFS, c & 32'hffbf);
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    resetn_i = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rdc("ctrl_reset", CTRL_OFS, 32'hffffffff, 32'(CTRL_RESET));
    rdc("count_reset", COUNT_OFS, 32'hffffffff, 32'(COUNT_RESET));
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    wr(CTRL_OFS, 32'h8000);
    rdc("rdir_readonly", CTRL_OFS, 32'h8000, 32'h0);
    for (int i = 0; i < 6; i++) begin
      run_for(16'h0, cw(MODE_TIMER, 3'(pt[i]), 1'b1, 2'(bt[i])), 16 * dv[i], 0);
      chk("timer_rate", 32'(count >= 16'd15 && count <= 16'd18), 32'h1);
    end
    run_for(16'h5, cw(MODE_TIMER, 3'h0, 1'b0, 2'h1), 64, 0);
    chk("run_off_hold", 32'(count), 32'h5);
    run_for(16'h3, cw(MODE_TIMER, 3'h0, 1'b1, 2'h1) | 32'h80, 64, 0);
    chk("count_down_wrap", 32'(count > 16'hff00), 32'h1);
    chk("wrap_latch_flags", cst & 32'hc400, 32'hc400);
    run_for(16'h0, cw(MODE_TIMER, 3'h0, 1'b1, 2'h1) | 32'h180, 64, 0);
    chk("ext_dir_up", 32'(count >= 16'd15 && count <= 16'd18), 32'h1);
    chk("ext_dir_status", cst & 32'hc000, 32'h4000);
    line.set_dir(1'b1);
    run_for(16'h0, cw(MODE_TIMER, 3'h0, 1'b1, 2'h1) | 32'h180, 64, 0);
    chk("ext_dir_down", 32'(count > 16'hff00), 32'h1);
    line.set_dir(1'b0);
    // gate low mode counts while the idle input sits low, gate high does not
    run_for(16'h0, cw(MODE_GATE_LO, 3'h0, 1'b1, 2'h1), 64, 0);
    chk("gate_low", 32'(count >= 16'd15 && count <= 16'd18), 32'h1);
    run_for(16'h0, cw(MODE_GATE_HI, 3'h0, 1'b1, 2'h1), 64, 0);
    chk("gate_high", 32'(count), 32'h0);
    run_for(16'h0, cw(3'h4, 3'h0, 1'b1, 2'h1), 64, 0);
    chk("reserved_stop", 32'(count), 32'h0);
    for (int p = 0; p < 4; p++) begin
      run_for(16'h0, cw(MODE_COUNTER, 3'(p), 1'b1, 2'h0), 8, 3);
      chk("counter_edges", 32'(count), 32'(3 * per[p]));
      chk("edge_flag_set", 32'(cst[EDGE_POS]), 32'(p != 0));
      rdc("edge_flag_clear", CTRL_OFS, 32'h2000, 32'h0);
    end
    // incremental mode, direction line low: each rise counts down, each fall up
    run_for(16'h0, cw(MODE_INC_EDGE, 3'h1, 1'b1, 2'h0), 8, 3);
    chk("incr_count", 32'(count), 32'h0);
    chk("incr_flags", cst & 32'he400, 32'h6000);
    wr(CTRL_OFS, 32'h0600);
    repeat (2) @(posedge clk_sys_i);
    chk("toggle_pin_set", {31'h0, pin}, 32'h1);
    wr(CTRL_OFS, 32'h0200);
    repeat (2) @(posedge clk_sys_i);
    chk("toggle_pin_clear", {31'h0, pin}, 32'h0);
    tally_and_finish();
  end
endmodule // testbench
